// >>> logic/lcd_timing_pkg.sv
// shared constants for the lcd timing core
package lcd_timing_pkg;
   localparam int IDX_W  = 5;
   localparam int MA_W   = 16;
   localparam int RAS_W  = 5;
   localparam int SYNC_W = 32;
   localparam int FIFO_W = 16;
   localparam int FIFO_D = 4;
   // data register indices
   localparam logic [4:0] IDX_HDISP    = 5'h01;
   localparam logic [4:0] IDX_MAXRAS   = 5'h09;
   localparam logic [4:0] IDX_CURSTART = 5'h0A;
   localparam logic [4:0] IDX_CUREND   = 5'h0B;
   localparam logic [4:0] IDX_STARTH   = 5'h0C;
   localparam logic [4:0] IDX_STARTL   = 5'h0D;
   localparam logic [4:0] IDX_CURH     = 5'h0E;
   localparam logic [4:0] IDX_CURL     = 5'h0F;
   localparam logic [4:0] IDX_VWIDTH   = 5'h12;
   localparam logic [4:0] IDX_DUTYH    = 5'h13;
   localparam logic [4:0] IDX_DUTYL    = 5'h14;
   localparam logic [4:0] IDX_DSTART   = 5'h15;
   localparam logic [4:0] IDX_MODE     = 5'h16;
   // field positions
   localparam int BLINK_HI    = 6;
   localparam int BLINK_LO    = 5;
   localparam int MODE_GRAPH  = 0;
   localparam int MODE_WIDE   = 2;
   localparam int MODE_ATTR   = 3;
   localparam int ATTR_REV    = 8;
   localparam int BLINK32_BIT = 4;
   localparam int BLINK64_BIT = 5;
   localparam logic [1:0] BLINK_STEADY = 2'h0;
   localparam logic [1:0] BLINK_OFF    = 2'h1;
   localparam logic [1:0] BLINK_32     = 2'h2;
   localparam logic [1:0] BLINK_64     = 2'h3;
   // timing counts, one dot per clock
   localparam logic [3:0] DOT_LAST_NARROW = 4'h7;
   localparam logic [3:0] DOT_LAST_WIDE   = 4'hF;
   localparam logic [7:0] HBLANK_CHARS    = 8'h04;
   localparam logic [2:0] STEP_LAST       = 3'h7;
endpackage : lcd_timing_pkg

// >>> logic/pin_sync.sv
// two-flop synchroniser bank for pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_ff;
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               meta_ff     <= 1'h0;
               sync_out[i] <= 1'h0;
            end else begin
               meta_ff     <= async_in[i];
               sync_out[i] <= meta_ff;
            end
         end
      end
   endgenerate
endmodule : pin_sync
`default_nettype wire

// >>> logic/sync_fifo.sv
// small fall-through fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
   parameter int W = 16,
   parameter int D = 4
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_ff [D];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [AW:0]   cnt_ff;
   logic          push;
   logic          pop;
   // count is one bit wider than the pointers so full is seen at exactly D
   assign in_ready  = (cnt_ff < (AW+1)'(D));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rp_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_ff @(posedge clock) begin
      if (push) begin
         mem_ff[wp_ff] <= in_data;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
         if (pop) rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sync_fifo
`default_nettype wire

// >>> logic/lcd_timing_register_core.sv
// lcd timing core: registers, raster and row counters, lcd output timing
// Behaviour
// - row shows set chars, 8 or 16 dots
// - raster register N gives N+1 rasters
// - blink code: steady, off, 32, 64 frames
// - cursor between start and end raster
// - each frame starts at start address
// - cursor address readable, others read zero
// - next row start adds virtual width
// - top row begins at display start raster
// - mode setting is register bit or pin
// - reset pin clears dot, char and line counters, keeps frame count and registers
// - lcd outputs hold, shift clock set by mode; memory address and display timing low, memory clock high in reset
// - registers accessible during reset pin
// - mode bits 0, 2, 3 select graphic, wide, attribute
// - select low writes index; unmapped writes ignored
`timescale 1ns/1ps
`default_nettype none
module lcd_timing_register_core (
   input  wire logic                           clock,
   input  wire logic                           reset_n,
   input  wire logic                           reset_n_in,
   input  wire logic                           chip_select_n,
   input  wire logic                           read_n,
   input  wire logic                           write_n,
   input  wire logic                           register_select,
   input  wire logic [7:0]                     db_in,
   output logic      [7:0]                     db_out,
   output logic                                db_oe_n,
   input  wire logic                           pin_graphic,
   input  wire logic                           pin_wide,
   input  wire logic                           attribute_select,
   input  wire logic [lcd_timing_pkg::MA_W-1:0] memory_data_in,
   output logic      [lcd_timing_pkg::MA_W-1:0] memory_address_out,
   output logic      [lcd_timing_pkg::RAS_W-1:0] raster_address_out,
   output logic                                display_timing_out,
   output logic                                cursor_display_out,
   output logic                                memory_clock_out,
   output logic                                line_latch_clock,
   output logic                                data_shift_clock,
   output logic                                first_line_marker,
   output logic      [3:0]                     upper_panel_data,
   output logic      [3:0]                     lower_panel_data
);
   import lcd_timing_pkg::*;

   logic              rst_meta_ff;
   logic              rst_n_ff;
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_syn;
   logic              s_res_n, s_cs_n, s_rd_n, s_wr_n, s_rs;
   logic              s_graph, s_wide, s_attr;
   logic [7:0]        s_db;
   logic [MA_W-1:0]   s_md;
   logic              wr_prev_ff;
   logic              wr_take;
   logic [IDX_W-1:0]  index_ff;
   logic [7:0]        hdisp_ff;
   logic [RAS_W-1:0]  maxras_ff;
   logic [6:0]        curstart_ff;
   logic [RAS_W-1:0]  curend_ff;
   logic [MA_W-1:0]   start_ff;
   logic [MA_W-1:0]   cursor_ff;
   logic [7:0]        vwidth_ff;
   logic [8:0]        duty_ff;
   logic [RAS_W-1:0]  dstart_ff;
   logic [3:0]        mode_ff;
   logic              res;
   logic              graph, wide16, attr;
   logic [3:0]        dot_last;
   logic [3:0]        dot_ff;
   logic [7:0]        char_ff;
   logic [8:0]        line_ff;
   logic [RAS_W-1:0]  raster_ff;
   logic [MA_W-1:0]   row_ff;
   logic [5:0]        frame_ff;
   logic [7:0]        line_chars;
   logic              run, char_end, line_end, frame_end, row_end;
   logic              disp, blink_on, cur_hit;
   logic [MA_W-1:0]   nxt_ma;
   logic [2:0]        step_ff;
   logic              step_en;
   logic              fifo_in_ready, fifo_out_valid, pop;
   logic [FIFO_W-1:0] fifo_out;
   logic [FIFO_W-1:0] word;
   logic [7:0]        sh_ff;
   logic              left_ff;

   // reset release through two flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_ff <= 1'h0;
         rst_n_ff    <= 1'h0;
      end else begin
         rst_meta_ff <= 1'h1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   // every pin crosses two flops before use
   assign pins_raw = {reset_n_in, chip_select_n, read_n, write_n, register_select,
                      pin_graphic, pin_wide, attribute_select, db_in, memory_data_in};
   pin_sync #(.W(SYNC_W)) u_sync (
      .clock    (clock),
      .rst_n    (rst_n_ff),
      .async_in (pins_raw),
      .sync_out (pins_syn)
   );
   assign {s_res_n, s_cs_n, s_rd_n, s_wr_n, s_rs, s_graph, s_wide, s_attr, s_db, s_md} = pins_syn;
   assign res = !s_res_n;

   // write taken on rising edge of the write strobe
   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) wr_prev_ff <= 1'h1;
      else wr_prev_ff <= s_wr_n;
   end
   assign wr_take = !wr_prev_ff && s_wr_n && !s_cs_n;

   // writes land whether or not the reset pin is low
   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         index_ff    <= '0;
         hdisp_ff    <= '0;
         maxras_ff   <= '0;
         curstart_ff <= '0;
         curend_ff   <= '0;
         start_ff    <= '0;
         cursor_ff   <= '0;
         vwidth_ff   <= '0;
         duty_ff     <= '0;
         dstart_ff   <= '0;
         mode_ff     <= '0;
      end else if (wr_take && !s_rs) begin
         index_ff <= s_db[IDX_W-1:0];
      end else if (wr_take) begin
         if (index_ff == IDX_HDISP) hdisp_ff <= s_db;
         else if (index_ff == IDX_MAXRAS) maxras_ff <= s_db[RAS_W-1:0];
         else if (index_ff == IDX_CURSTART) curstart_ff <= s_db[6:0];
         else if (index_ff == IDX_CUREND) curend_ff <= s_db[RAS_W-1:0];
         else if (index_ff == IDX_STARTH) start_ff[15:8] <= s_db;
         else if (index_ff == IDX_STARTL) start_ff[7:0] <= s_db;
         else if (index_ff == IDX_CURH) cursor_ff[15:8] <= s_db;
         else if (index_ff == IDX_CURL) cursor_ff[7:0] <= s_db;
         else if (index_ff == IDX_VWIDTH) vwidth_ff <= s_db;
         else if (index_ff == IDX_DUTYH) duty_ff[8] <= s_db[0];
         else if (index_ff == IDX_DUTYL) duty_ff[7:0] <= s_db;
         else if (index_ff == IDX_DSTART) dstart_ff <= s_db[RAS_W-1:0];
         else if (index_ff == IDX_MODE) mode_ff <= s_db[3:0];
      end
   end

   // cursor address read back; others read zero
   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         db_out  <= 8'h00;
         db_oe_n <= 1'h1;
      end else begin
         db_oe_n <= !(!s_rd_n && !s_cs_n && s_rs);
         if (index_ff == IDX_CURH) db_out <= cursor_ff[15:8];
         else if (index_ff == IDX_CURL) db_out <= cursor_ff[7:0];
         else db_out <= 8'h00;
      end
   end

   // mode is register bit or pin
   assign graph  = mode_ff[MODE_GRAPH] | s_graph;
   assign attr   = mode_ff[MODE_ATTR] | s_attr;
   assign wide16 = graph | mode_ff[MODE_WIDE] | s_wide;
   assign dot_last   = wide16 ? DOT_LAST_WIDE : DOT_LAST_NARROW;
   assign line_chars = hdisp_ff + HBLANK_CHARS - 8'h01;
   // full fifo stalls the whole raster scan
   assign run        = !res && fifo_in_ready;
   assign char_end   = run && (dot_ff >= dot_last);
   assign line_end   = char_end && (char_ff >= line_chars);
   assign frame_end  = line_end && (line_ff >= duty_ff);
   assign row_end    = line_end && (raster_ff >= maxras_ff);
   assign disp       = char_ff < hdisp_ff;

   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         dot_ff  <= '0;
         char_ff <= '0;
         line_ff <= '0;
      end else if (res) begin
         dot_ff  <= '0;
         char_ff <= '0;
         line_ff <= '0;
      end else if (run) begin
         dot_ff <= char_end ? 4'h0 : dot_ff + 4'h1;
         if (line_end) char_ff <= 8'h00;
         else if (char_end) char_ff <= char_ff + 8'h01;
         if (frame_end) line_ff <= 9'h000;
         else if (line_end) line_ff <= line_ff + 9'h001;
      end
   end

   // frame restarts at start address and raster
   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         row_ff    <= '0;
         raster_ff <= '0;
         frame_ff  <= '0;
      end else if (res) begin
         row_ff    <= start_ff;
         raster_ff <= dstart_ff;
      end else if (frame_end) begin
         row_ff    <= start_ff;
         raster_ff <= dstart_ff;
         frame_ff  <= frame_ff + 6'h01;
      end else if (row_end) begin
         row_ff    <= row_ff + {8'h00, vwidth_ff};
         raster_ff <= '0;
      end else if (line_end) begin
         raster_ff <= raster_ff + 5'h01;
      end
   end

   always_comb begin
      case (curstart_ff[BLINK_HI:BLINK_LO])
         BLINK_STEADY: blink_on = 1'h1;
         BLINK_OFF:    blink_on = 1'h0;
         BLINK_32:     blink_on = frame_ff[BLINK32_BIT];
         default:      blink_on = frame_ff[BLINK64_BIT];
      endcase
   end
   assign nxt_ma  = row_ff + {8'h00, char_ff};
   assign cur_hit = (nxt_ma == cursor_ff) && blink_on
                    && (raster_ff >= curstart_ff[RAS_W-1:0]) && (raster_ff <= curend_ff);

   // memory side outputs during reset pin
   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         memory_address_out <= '0;
         display_timing_out <= 1'h0;
         cursor_display_out <= 1'h0;
         memory_clock_out   <= 1'h1;
      end else if (res) begin
         memory_address_out <= '0;
         display_timing_out <= 1'h0;
         cursor_display_out <= 1'h0;
         memory_clock_out   <= 1'h1;
      end else begin
         memory_address_out <= nxt_ma;
         display_timing_out <= disp;
         cursor_display_out <= disp && cur_hit;
         memory_clock_out   <= wide16 ? !dot_ff[3] : !dot_ff[2];
      end
   end

   // lcd strobes hold during reset pin
   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         raster_address_out <= '0;
         line_latch_clock   <= 1'h0;
         first_line_marker  <= 1'h0;
      end else if (!res) begin
         raster_address_out <= raster_ff;
         line_latch_clock   <= line_end;
         first_line_marker  <= (line_ff == 9'h000);
      end
   end

   // output step divider: one enable per eight clocks
   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) step_ff <= '0;
      else if (!res) step_ff <= step_ff + 3'h1;
   end
   assign step_en = !res && (step_ff == STEP_LAST);

   // shift clock fixed by mode in reset
   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) data_shift_clock <= 1'h0;
      else if (res) data_shift_clock <= wide16;
      else data_shift_clock <= step_ff[2];
   end

   // display words wait here; drain stops in reset, and no words enter while the scan is held
   sync_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n_ff),
      .in_valid  (char_end && disp),
      .in_ready  (fifo_in_ready),
      .in_data   (s_md),
      .out_valid (fifo_out_valid),
      .out_ready (pop),
      .out_data  (fifo_out)
   );
   assign pop  = step_en && !left_ff;
   // reverse video from the attribute byte in character mode
   assign word = (attr && !graph && fifo_out[ATTR_REV])
                 ? {fifo_out[15:8], ~fifo_out[7:0]} : fifo_out;

   // panel data holds while reset pin low
   always_ff @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         upper_panel_data <= '0;
         lower_panel_data <= '0;
         sh_ff            <= '0;
         left_ff          <= 1'h0;
      end else if (step_en) begin
         if (left_ff) begin
            upper_panel_data <= sh_ff[3:0];
            lower_panel_data <= sh_ff[7:4];
            left_ff          <= 1'h0;
         end else if (fifo_out_valid) begin
            upper_panel_data <= word[3:0];
            lower_panel_data <= word[7:4];
            sh_ff            <= word[15:8];
            left_ff          <= wide16;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n_ff);

   property p_pitch;
      char_end && (dot_ff == DOT_LAST_NARROW) |-> !wide16;
   endproperty
   a_pitch: assert property (p_pitch) else $error("narrow pitch in wide mode");
   property p_raster_wrap;
      row_end && !frame_end |=> raster_ff == 5'h00;
   endproperty
   a_raster_wrap: assert property (p_raster_wrap) else $error("raster did not wrap");
   property p_blink_off;
      curstart_ff[BLINK_HI:BLINK_LO] == BLINK_OFF |=> !cursor_display_out;
   endproperty
   a_blink_off: assert property (p_blink_off) else $error("cursor shown while off");
   property p_frame_start;
      frame_end |=> row_ff == $past(start_ff) && raster_ff == $past(dstart_ff);
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame start wrong");
   property p_row_add;
      row_end && !frame_end |=> row_ff == $past(row_ff) + {8'h00, $past(vwidth_ff)};
   endproperty
   a_row_add: assert property (p_row_add) else $error("row start not advanced");
   property p_scroll;
      res ##1 !res |-> raster_ff == $past(dstart_ff);
   endproperty
   a_scroll: assert property (p_scroll) else $error("top raster not start raster");
   property p_mode_or;
      (mode_ff[MODE_WIDE] || s_wide) && char_end |-> dot_ff == DOT_LAST_WIDE;
   endproperty
   a_mode_or: assert property (p_mode_or) else $error("wide mode ignored");
   property p_keep_regs;
      res && !wr_take |=> $stable(start_ff) && $stable(vwidth_ff) && char_ff == 8'h00;
   endproperty
   a_keep_regs: assert property (p_keep_regs) else $error("reset pin hit registers");
   property p_reset_pins;
      res |=> memory_clock_out && !display_timing_out && $stable(upper_panel_data);
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("reset pin states wrong");
   property p_write_in_reset;
      wr_take && s_rs && index_ff == IDX_VWIDTH |=> vwidth_ff == $past(s_db);
   endproperty
   a_write_in_reset: assert property (p_write_in_reset) else $error("write lost");
   property p_cursor_disp;
      cursor_display_out |-> display_timing_out;
   endproperty
   a_cursor_disp: assert property (p_cursor_disp) else $error("cursor outside display");
   c_frame: cover property (frame_end);
   c_cursor: cover property (cursor_display_out);
   c_fifo_full: cover property (!fifo_in_ready && !res);
   c_read: cover property (!db_oe_n);
endmodule : lcd_timing_register_core
`default_nettype wire

// >>> verif/lcd_driver_model.sv
// lcd driver stand-in: counts latched lines between frame markers
`timescale 1ns/1ps
`default_nettype none
module lcd_driver_model (
   input  wire logic        clock,
   input  wire logic        line_latch_clock,
   input  wire logic        first_line_marker,
   output logic      [15:0] lines_per_frame
);
   logic [15:0] line_cnt_ff = 16'h0000;
   logic        flm_q_ff    = 1'b0;
   always_ff @(posedge clock) begin
      flm_q_ff <= first_line_marker;
      if (first_line_marker && !flm_q_ff) begin
         lines_per_frame <= line_cnt_ff;
         line_cnt_ff     <= {15'h0000, line_latch_clock};
      end else if (line_latch_clock) begin
         line_cnt_ff <= line_cnt_ff + 16'h0001;
      end
   end
endmodule : lcd_driver_model
`default_nettype wire

// >>> verif/lcd_timing_register_core_tb_top.sv
// self-checking bench for the lcd timing core
`timescale 1ns/1ps
`default_nettype none
module lcd_timing_register_core_tb_top;
   import lcd_timing_pkg::*;
   logic        clock, reset_n, reset_n_in, chip_select_n, read_n, write_n, register_select;
   logic        pin_graphic, pin_wide, attribute_select, db_oe_n, display_timing_out;
   logic        cursor_display_out, memory_clock_out, line_latch_clock, data_shift_clock;
   logic        first_line_marker;
   logic [7:0]  db_in, db_out, rd_val;
   logic [15:0] memory_data_in, memory_address_out, lines_per_frame, row_a;
   logic [4:0]  raster_address_out, row_r;
   logic [3:0]  upper_panel_data, lower_panel_data;
   int          err_total, check_count, n, hits;
   logic [15:0] exp_a [5] = '{16'h0100, 16'h0100, 16'h0104, 16'h0104, 16'h0100};
   logic [4:0]  exp_r [5] = '{5'h00, 5'h01, 5'h00, 5'h01, 5'h00};
   logic [3:0]  md [6] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h1, 4'h8};
   logic [1:0]  pg [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
   int          fr [4] = '{2, 2, 32, 64};
   int          ex [4] = '{2, 0, 16, 32};

   lcd_timing_register_core uut (.clock, .reset_n, .reset_n_in, .chip_select_n, .read_n,
      .write_n, .register_select, .db_in, .db_out, .db_oe_n, .pin_graphic, .pin_wide,
      .attribute_select, .memory_data_in, .memory_address_out, .raster_address_out,
      .display_timing_out, .cursor_display_out, .memory_clock_out, .line_latch_clock,
      .data_shift_clock, .first_line_marker, .upper_panel_data, .lower_panel_data);
   lcd_driver_model drv (.clock, .line_latch_clock, .first_line_marker, .lines_per_frame);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // memory answers with a word derived from the address
   always @(negedge clock) memory_data_in <= memory_address_out ^ 16'h00FF;

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic rs, input logic [7:0] d);
      @(negedge clock);
      chip_select_n = 1'b0; register_select = rs; db_in = d; write_n = 1'b0;
      repeat (5) @(negedge clock);
      write_n = 1'b1;
      repeat (5) @(negedge clock);
      chip_select_n = 1'b1;
   endtask : wr
   task automatic reg_wr(input logic [4:0] idx, input logic [7:0] d);
      wr(1'b0, {3'h0, idx});
      wr(1'b1, d);
   endtask : reg_wr
   task automatic rd(input logic [4:0] idx, output logic [7:0] d);
      wr(1'b0, {3'h0, idx});
      @(negedge clock);
      chip_select_n = 1'b0; register_select = 1'b1; read_n = 1'b0;
      repeat (5) @(negedge clock);
      d = db_out;
      check({15'h0000, db_oe_n}, 16'h0000);
      read_n = 1'b1;
      repeat (5) @(negedge clock);
      chip_select_n = 1'b1;
   endtask : rd
   task automatic wait_line(output int c);
      c = 0;
      do begin
         @(negedge clock);
         c++;
      end while (line_latch_clock !== 1'b1 && c < 2000);
   endtask : wait_line
   task automatic seen_dots(input logic [7:0] v, output int s);
      s = 0;
      repeat (192) begin
         @(negedge clock);
         if ({lower_panel_data, upper_panel_data} === v) s = 1;
      end
   endtask : seen_dots
   task automatic next_row(output logic [15:0] a, output logic [4:0] r);
      int k;
      k = 0;
      while (display_timing_out === 1'b1 && k < 2000) begin
         @(negedge clock);
         k++;
      end
      while (display_timing_out !== 1'b1 && k < 2000) begin
         @(negedge clock);
         k++;
      end
      a = memory_address_out;
      r = raster_address_out;
   endtask : next_row
   task automatic pulse_pin_reset();
      reset_n_in = 1'b0;
      repeat (100) @(negedge clock);
      reset_n_in = 1'b1;
   endtask : pulse_pin_reset
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   initial begin
      #600000;
      err_total++;
      wrap_up();
   end

   initial begin
      err_total = 0; check_count = 0;
      reset_n = 1'b0; reset_n_in = 1'b1; chip_select_n = 1'b1; read_n = 1'b1;
      write_n = 1'b1; register_select = 1'b0; db_in = 8'h00;
      pin_graphic = 1'b0; pin_wide = 1'b0; attribute_select = 1'b0;
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      repeat (10) @(negedge clock);
      // scroll, geometry within limits
      // 4-line single screen, duty 3; 2 rasters per row, width 4
      reg_wr(IDX_HDISP, 8'h02); reg_wr(IDX_MAXRAS, 8'h01); reg_wr(IDX_CURSTART, 8'h00);
      reg_wr(IDX_CUREND, 8'h00); reg_wr(IDX_STARTH, 8'h01); reg_wr(IDX_STARTL, 8'h00);
      reg_wr(IDX_CURH, 8'h01); reg_wr(IDX_CURL, 8'h00); reg_wr(IDX_VWIDTH, 8'h04);
      reg_wr(IDX_DUTYH, 8'h00); reg_wr(IDX_DUTYL, 8'h03); reg_wr(IDX_DSTART, 8'h00);
      reg_wr(IDX_MODE, 8'h00);
      rd(IDX_CURH, rd_val); check({8'h00, rd_val}, 16'h0001);
      rd(IDX_CURL, rd_val); check({8'h00, rd_val}, 16'h0000);
      rd(IDX_VWIDTH, rd_val); check({8'h00, rd_val}, 16'h0000);
      reg_wr(5'h02, 8'h55);
      rd(IDX_CURH, rd_val); check({8'h00, rd_val}, 16'h0001);
      $display("register access done");
      reset_n_in = 1'b0;
      repeat (100) @(negedge clock);
      check({15'h0000, memory_clock_out}, 16'h0001);
      check({15'h0000, data_shift_clock}, 16'h0000);
      reg_wr(IDX_CURL, 8'h5A);
      rd(IDX_CURL, rd_val); check({8'h00, rd_val}, 16'h005A);
      reg_wr(IDX_CURL, 8'h00);
      reset_n_in = 1'b1;
      for (int i = 0; i < 5; i++) begin
         next_row(row_a, row_r);
         check(row_a, exp_a[i]);
         check({11'h000, row_r}, {11'h000, exp_r[i]});
      end
      // one extra line so a whole frame has been latched by the model
      wait_line(n); wait_line(n); wait_line(n); wait_line(n); wait_line(n);
      check(lines_per_frame, 16'h0004);
      reg_wr(IDX_DSTART, 8'h01);
      pulse_pin_reset();
      next_row(row_a, row_r);
      check({11'h000, row_r}, 16'h0001);
      next_row(row_a, row_r);
      check(row_a, 16'h0104);
      reg_wr(IDX_DSTART, 8'h00);
      $display("frame scan done");
      seen_dots(8'hFF, n); check(16'(n), 16'h0001);
      seen_dots(8'hFB, n); check(16'(n), 16'h0001);
      seen_dots(8'hFD, n); check(16'(n), 16'h0000);
      for (int i = 0; i < 6; i++) begin
         reg_wr(IDX_MODE, {4'h0, md[i]});
         pin_graphic = pg[i][0]; pin_wide = pg[i][1];
         wait_line(n); wait_line(n); wait_line(n);
         check(16'(n), 16'((2 + 4) * ((md[i][2:0] != 3'h0 || pg[i] != 2'h0) ? 16 : 8)));
      end
      reg_wr(IDX_MODE, 8'h00); pin_graphic = 1'b0; pin_wide = 1'b0;
      $display("mode timing done");
      for (int b = 0; b < 4; b++) begin
         reg_wr(IDX_CURSTART, {1'b0, 2'(b), 5'h00});
         wait_line(n); wait_line(n);
         hits = 0;
         repeat (fr[b]) begin
            n = 0;
            repeat (192) begin
               @(negedge clock);
               if (cursor_display_out === 1'b1) n = 1;
            end
            hits += n;
         end
         check(16'(hits), 16'(ex[b]));
      end
      $display("cursor done");
      wrap_up();
   end
endmodule : lcd_timing_register_core_tb_top
`default_nettype wire
